// file: include/app_adv_pkg.sv
/*
 * package for the application descriptor advertising block: register
 * offsets, field positions, table geometry and reset values.
 * assumes an ahb-lite slave with 32-bit data, one word per register.
 */
package app_adv_pkg;
	// table geometry
	localparam int unsigned max_desc = 15;
	localparam int unsigned first_region_desc = 8;
	localparam int unsigned desc_bytes = 5;
	localparam int unsigned sel_w = 4;

	// word map: descriptor n (1..15) main word at desc_base + 4*(n-1)
	localparam logic [11:0] desc_base_off = 12'h000;
	// second region holds codes 9..15
	localparam logic [11:0] desc_region2_off = 12'h020;
	// media start-lane maps live on their own page
	localparam logic [11:0] media_map_base_off = 12'h100;
	// control and status words
	localparam logic [11:0] query_sel_off = 12'h200;
	localparam logic [11:0] query_info_off = 12'h204;
	localparam logic [11:0] table_status_off = 12'h208;
	localparam logic [11:0] lane_check_off = 12'h20c;
	localparam logic [11:0] map_end_off = 12'h20c;

	// byte positions inside the main descriptor word
	localparam int unsigned host_code_lsb = 0;
	localparam int unsigned media_code_lsb = 8;
	localparam int unsigned lane_pair_lsb = 16;
	localparam int unsigned host_map_lsb = 24;
	// nibble positions inside the lane count byte
	localparam int unsigned host_total_lsb = 4;
	localparam int unsigned media_total_lsb = 0;

	// codes
	localparam logic [7:0] end_of_list_code = 8'hff;
	localparam logic [7:0] media_undefined_code = 8'h00;
	localparam logic [3:0] total_from_code = 4'h0;
	localparam logic [3:0] total_max = 4'h8;
	localparam logic [3:0] sel_unused = 4'h0;
	localparam logic [3:0] sel_default = 4'h1;

	// reset value of the writable word and default read data
	localparam logic [3:0] query_sel_reset = 4'h1;
	localparam logic [31:0] read_default = 32'h0000_0000;
endpackage

// file: design/desc_rom.sv
/*
 * descriptor store: fifteen five-byte entries held as constants, read
 * through one registered port.
 * assumes the contents are fixed at build time by the parameter.
 */
`timescale 1ns/1ns
module desc_rom #(
	parameter int unsigned depth = 15,
	parameter logic [40*15-1:0] contents = '0
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// read port
	input wire logic [3:0] rd_index,
	output logic [39:0] rd_entry
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_entry <= '0;
		end else if (rd_index < 4'(depth)) begin
			rd_entry <= contents[rd_index*40 +: 40];
		end else begin
			rd_entry <= {32'h0000_0000, app_adv_pkg::end_of_list_code};
		end
	end
endmodule // desc_rom

// file: design/lane_fit.sv
/*
 * checks whether a host or media lane group from a start lane fits within eight
 * lanes and reports the mask of all lanes that the instance covers.
 * assumes a lane total of 1..8; zero is taken as one lane.
 */
`timescale 1ns/1ns
module lane_fit (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// query
	input wire logic [7:0] start_map,
	input wire logic [3:0] lane_total,
	// result
	output logic [7:0] cover_mask,
	output logic fits
);
	function automatic logic [7:0] group_mask(input logic [7:0] starts,
		input logic [3:0] n);
		logic [7:0] m;
		logic [15:0] w;
		m = '0;
		for (int i = 0; i < 8; i++) begin
			if (starts[i]) begin
				w = ({8'h00, 8'hff} >> (8 - n)) << i;
				m = m | w[7:0];
			end
		end
		return m;
	endfunction

	logic [3:0] n_eff;
	logic [7:0] bad;
	assign n_eff = (lane_total == 4'h0 || lane_total > 4'h8) ? 4'h1
		: lane_total;

	// a start too near the top would run past lane eight
	always_comb begin
		bad = '0;
		for (int i = 0; i < 8; i++) begin
			bad[i] = start_map[i] && ((i + int'(n_eff)) > 8);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cover_mask <= '0;
			fits <= 1'b0;
		end else begin
			cover_mask <= group_mask(start_map, n_eff);
			fits <= (bad == 8'h00);
		end
	end
endmodule // lane_fit

// file: design/app_adv_regs.sv
/*
 * application descriptor advertising bank: a read-only table of up to
 * fifteen supported host/media configurations plus a small query port,
 * reached by ahb-lite.
 * assumes a single ahb-lite master, word transfers, hready from us.
 */
`timescale 1ns/1ns
module app_adv_regs #(
	parameter int unsigned num_valid = 2,
	parameter logic paged = 1'b1,
	parameter logic [7:0] category = 8'h01,
	// entry k at bits [40*k +: 40]: {media map, host map, lanes, media, host}
	parameter logic [40*15-1:0] table_init = {
		{13{40'h00_00_00_00_ff}},
		40'h0f_55_12_03_04,
		40'h01_01_84_08_02}
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// selected configuration seen by the data path
	output logic [3:0] active_sel_r,
	output logic sel_valid_r,
	// media category advertised elsewhere
	output logic [7:0] media_category
);
	// entries past the valid count are forced to the end marker so that
	// a bad parameter cannot advertise an unsupported entry
	function automatic logic [39:0] entry_of(input int unsigned k);
		logic [39:0] e;
		e = table_init[k*40 +: 40];
		// a reserved lane count cannot stand for a real configuration
		if (e[app_adv_pkg::lane_pair_lsb + app_adv_pkg::host_total_lsb +: 4]
			> app_adv_pkg::total_max ||
			e[app_adv_pkg::lane_pair_lsb + app_adv_pkg::media_total_lsb +: 4]
			> app_adv_pkg::total_max) begin
			e = {32'h0000_0000, app_adv_pkg::end_of_list_code};
		end
		if (k >= num_valid) begin
			e = {32'h0000_0000, app_adv_pkg::end_of_list_code};
		end
		if (!paged) begin
			e[39:32] = 8'h00;
		end
		return e;
	endfunction

	function automatic logic [40*15-1:0] build_table();
		logic [40*15-1:0] t;
		t = '0;
		for (int k = 0; k < 15; k++) begin
			t[k*40 +: 40] = entry_of(k);
		end
		return t;
	endfunction

	localparam logic [40*15-1:0] table_eff = build_table();

	// byte address to descriptor slot, 0 means none
	function automatic logic [3:0] slot_of(input logic [11:0] a,
		input logic [11:0] base);
		logic [11:0] d;
		d = a - base;
		if (a >= base && d < 12'(4 * app_adv_pkg::max_desc)) begin
			return 4'(d[5:2]) + 4'h1;
		end
		return 4'h0;
	endfunction

	typedef enum logic [3:0] {
		st_idle = 4'b0001,
		st_fetch = 4'b0010,
		st_check = 4'b0100,
		st_load = 4'b1000
	} bus_state_e;

	bus_state_e state_r;
	logic [11:0] addr_r;
	logic write_r;
	logic [3:0] query_sel_r;
	logic [3:0] rom_index;
	logic [39:0] rom_entry;
	logic [7:0] cover_mask;
	logic fits;
	logic [7:0] media_cover;
	logic media_fits;
	logic word_r;
	logic [3:0] valid_count;
	logic take;
	logic [3:0] slot_main;
	logic [3:0] slot_media;

	assign take = hsel && hready && htrans[1];
	assign slot_main = slot_of(addr_r, app_adv_pkg::desc_base_off);
	assign slot_media = slot_of(addr_r, app_adv_pkg::media_map_base_off);

	// count of leading valid entries, the host may use codes 1..count
	always_comb begin
		valid_count = 4'h0;
		for (int k = app_adv_pkg::max_desc - 1; k >= 0; k--) begin
			if (table_eff[k*40 +: 8] == app_adv_pkg::end_of_list_code) begin
				valid_count = 4'(k);
			end
		end
		if (table_eff[7:0] != app_adv_pkg::end_of_list_code &&
			valid_count == 4'h0) begin
			valid_count = 4'(app_adv_pkg::max_desc);
		end
	end

	// rom fetch: main or media slot, else the queried entry
	always_comb begin
		if (slot_main != 4'h0) begin
			rom_index = slot_main - 4'h1;
		end else if (slot_media != 4'h0) begin
			rom_index = slot_media - 4'h1;
		end else if (query_sel_r != app_adv_pkg::sel_unused) begin
			rom_index = query_sel_r - 4'h1;
		end else begin
			rom_index = 4'h0;
		end
	end

	desc_rom #(
		.depth(app_adv_pkg::max_desc),
		.contents(table_eff)
	) u_rom (
		.hclk(hclk),
		.hresetn(hresetn),
		.rd_index(rom_index),
		.rd_entry(rom_entry)
	);

	// contiguous group check of the queried entry
	lane_fit u_fit (
		.hclk(hclk),
		.hresetn(hresetn),
		.start_map(rom_entry[app_adv_pkg::host_map_lsb +: 8]),
		.lane_total(rom_entry[app_adv_pkg::lane_pair_lsb +
			app_adv_pkg::host_total_lsb +: 4]),
		.cover_mask(cover_mask),
		.fits(fits)
	);

	// same check on the media side of the queried entry
	lane_fit u_media_fit (
		.hclk(hclk),
		.hresetn(hresetn),
		.start_map(rom_entry[39:32]),
		.lane_total(rom_entry[app_adv_pkg::lane_pair_lsb +
			app_adv_pkg::media_total_lsb +: 4]),
		.cover_mask(media_cover),
		.fits(media_fits)
	);

	// bus sequencing: three wait states, since the rom and then the lane
	// check each add a register before the read word can be formed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= st_idle;
			addr_r <= '0;
			write_r <= 1'b0;
			word_r <= 1'b0;
			hreadyout <= 1'b1;
		end else begin
			case (state_r)
				st_idle: begin
					if (take) begin
						state_r <= st_fetch;
						addr_r <= haddr[11:0];
						write_r <= hwrite;
						word_r <= (hsize == 3'b010);
						hreadyout <= 1'b0;
					end
				end
				st_fetch: begin
					state_r <= st_check;
				end
				st_check: begin
					state_r <= st_load;
				end
				st_load: begin
					// idle again so the next address phase is seen at once
					state_r <= st_idle;
					hreadyout <= 1'b1;
				end
				default: begin
					state_r <= st_idle;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// read data assembled in the last wait cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= app_adv_pkg::read_default;
		end else if (state_r == st_load && !write_r) begin
			if (slot_main != 4'h0) begin
				hrdata <= rom_entry[31:0];
			end else if (slot_media != 4'h0) begin
				hrdata <= {24'h000000, rom_entry[39:32]};
			end else if (addr_r == app_adv_pkg::query_sel_off) begin
				hrdata <= {28'h0000000, query_sel_r};
			end else if (addr_r == app_adv_pkg::query_info_off) begin
				hrdata <= {16'h0000, category, 7'h00,
					query_sel_r == app_adv_pkg::sel_unused};
			end else if (addr_r == app_adv_pkg::table_status_off) begin
				hrdata <= {20'h00000, 3'h0, paged, valid_count, sel_valid_r,
					active_sel_r[2:0]};
			end else if (addr_r == app_adv_pkg::lane_check_off) begin
				hrdata <= {7'h00, media_fits, media_cover, 7'h00, fits,
					cover_mask};
			end else begin
				hrdata <= app_adv_pkg::read_default;
			end
		end
	end

	// only the query selector is writable; descriptor writes vanish
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			query_sel_r <= app_adv_pkg::query_sel_reset;
		end else if (state_r == st_fetch && write_r && word_r &&
			addr_r == app_adv_pkg::query_sel_off) begin
			query_sel_r <= hwdata[3:0];
		end
	end

	// selection handed on to the data path; out of range codes drop to
	// unused since behaviour there is otherwise undefined
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			active_sel_r <= app_adv_pkg::sel_default;
			sel_valid_r <= 1'b0;
		end else if (query_sel_r == app_adv_pkg::sel_unused) begin
			active_sel_r <= app_adv_pkg::sel_unused;
			sel_valid_r <= 1'b0;
		end else if (query_sel_r <= valid_count) begin
			active_sel_r <= query_sel_r;
			sel_valid_r <= 1'b1;
		end else begin
			active_sel_r <= app_adv_pkg::sel_unused;
			sel_valid_r <= 1'b0;
		end
	end

	// media category output copies the category parameter; reset clears it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			media_category <= 8'h00;
		end else begin
			media_category <= category;
		end
	end
endmodule // app_adv_regs

// file: bench/app_adv_assertions.sv
/* port checker for the advertising bank.
 * assumes three wait states per transfer, as the bank answers. */
`timescale 1ns/1ns
module app_adv_assertions #(
	parameter int unsigned num_valid = 2,
	parameter logic [7:0] category = 8'h01
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// data path side
	input wire logic [3:0] active_sel_r,
	input wire logic sel_valid_r,
	input wire logic [7:0] media_category
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_req;
		hsel && hready && htrans[1];
	endsequence
	sequence s_wait;
		!hreadyout[*3] ##1 hreadyout;
	endsequence
	sequence s_sel_wr;
		s_req and (hwrite && haddr[11:0] == app_adv_pkg::query_sel_off);
	endsequence
	AST_WAIT_STATES: assert property (s_req |=> s_wait)
		else $error("transfer without three wait states");
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("response not okay");
	AST_END_MARK: assert property (s_req and (!hwrite &&
		haddr[11:0] == 12'(4 * num_valid)) |-> ##4 hrdata[7:0] == 8'hff)
		else $error("end marker missing");
	AST_DESC_RO: assert property (s_req and (hwrite &&
		haddr[11:0] != app_adv_pkg::query_sel_off) |=>
		$stable(active_sel_r)[*3])
		else $error("ignored write moved selection");
	AST_SEL_WR: assert property (s_sel_wr ##1 hwdata[3:0] == 4'h2
		|-> ##[0:3] active_sel_r == 4'h2)
		else $error("selection code not taken");
	AST_POWER_UP: assert property ($rose(hresetn) |=>
		active_sel_r == app_adv_pkg::sel_default && sel_valid_r)
		else $error("default selection missing after reset");
	AST_SEL_RANGE: assert property (sel_valid_r |->
		active_sel_r != 4'h0 && active_sel_r <= 4'(num_valid))
		else $error("valid flag on code outside list");
	AST_UNUSED: assert property ($past(hresetn) && !sel_valid_r |->
		active_sel_r == 4'h0)
		else $error("invalid selection not reported unused");
	AST_CATEGORY: assert property ($past(hresetn) |->
		media_category == category)
		else $error("media category wrong");
endmodule // app_adv_assertions

bind app_adv_regs app_adv_assertions #(.num_valid(num_valid),
	.category(category)) chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.active_sel_r(active_sel_r), .sel_valid_r(sel_valid_r),
	.media_category(media_category));

// file: bench/ahb_host.sv
/* host side model: single word ahb-lite transfers.
 * assumes each call starts just after a rising edge. */
`timescale 1ns/1ns
module ahb_host (
	// clock
	input wire logic hclk,
	// requests
	output logic hsel = 1'b0,
	output logic [31:0] haddr = 32'h0,
	output logic [1:0] htrans = 2'b00,
	output logic hwrite = 1'b0,
	output logic [2:0] hsize = 3'b010,
	output logic [31:0] hwdata = 32'h0,
	// answers
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		// released data lines must not look like held data
		hwdata <= ~wd;
	endtask
endmodule // ahb_host

// file: bench/application_descriptor_advertising_tb.sv
/* self-checking bench for the advertising bank.
 * assumes default table: two entries, paged, category 01. */
`timescale 1ns/1ns
module application_descriptor_advertising_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, sel_valid_r;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [3:0] active_sel_r;
	logic [7:0] media_category;
	int err_total = 0;
	int tests_run = 0;
	logic [11:0] row_a [12] = '{12'h000, 12'h004, 12'h008, 12'h020,
		12'h038, 12'h100, 12'h104, 12'h200, 12'h204, 12'h208, 12'h20c,
		12'h300};
	logic [31:0] row_d [12] = '{32'h0184_0802, 32'h5512_0304, 32'h0000_00ff,
		32'h0000_00ff, 32'h0000_00ff, 32'h0000_0001, 32'h0000_000f,
		32'h0000_0001, 32'h0000_0100, 32'h0000_0129, 32'h010f_01ff,
		32'h0000_0000};
	logic [3:0] sel_w [4] = '{4'h3, 4'h0, 4'h1, 4'h2};
	logic [3:0] sel_a [4] = '{4'h0, 4'h0, 4'h1, 4'h2};
	logic sel_v [4] = '{1'b0, 1'b0, 1'b1, 1'b1};

	always #4 hclk = ~hclk;

	ahb_host host (.hclk(hclk), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata));

	app_adv_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .active_sel_r(active_sel_r),
		.sel_valid_r(sel_valid_r), .media_category(media_category));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("mismatches=%0d checks=%0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// whole run needs well under 400 cycles
	initial begin
		#20000;
		err_total++;
		end_sim();
	end

	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 12; i++) begin
			host.xfer(1'b0, row_a[i], 32'h0, rd);
			check(rd, row_d[i]);
		end
		check({24'h0, media_category}, 32'h1);
		host.xfer(1'b1, 12'h000, 32'hdead_beef, rd);
		host.xfer(1'b0, 12'h000, 32'h0, rd);
		check(rd, row_d[0]);
		// a byte write to the selector must not land
		host.hsize <= 3'b000;
		host.xfer(1'b1, 12'h200, 32'h3, rd);
		host.hsize <= 3'b010;
		host.xfer(1'b0, 12'h200, 32'h0, rd);
		check(rd, 32'h1);
		// code 3 is past the list: a host fault on purpose
		for (int i = 0; i < 4; i++) begin
			host.xfer(1'b1, 12'h200, {28'h0, sel_w[i]}, rd);
			host.xfer(1'b0, 12'h208, 32'h0, rd);
			check({27'h0, sel_valid_r, active_sel_r},
				{27'h0, sel_v[i], sel_a[i]});
			check(rd, {24'h1, 4'h2, sel_v[i], sel_a[i][2:0]});
		end
		hresetn <= 1'b0;
		@(posedge hclk);
		check({27'h0, sel_valid_r, active_sel_r}, 32'h1);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		check({27'h0, sel_valid_r, active_sel_r}, 32'h11);
		end_sim();
	end
endmodule // application_descriptor_advertising_tb
